// file: logic/srbu_core.sv
// shift, rotate, bit shift register and diagnostic lamp datapath
// Contract
// (RQ1) logical shifts fill vacated bits with zero
// (RQ2) shift count at or above width saturates
// (RQ3) nonzero shift loads last bit out to overflow
// (RQ4) zero flag reflects shifted result
// (RQ5) byte unsigned; sign bit shifted, not extended
// (RQ6) rotates are circular
// (RQ7) rotate count reduced modulo operand width
// (RQ8) zero rotate count leaves operand, overflow untouched
// (RQ9) partial rotate copies last rotated bit out
// (RQ10) rotate zero flag from input operand
// (RQ11) bad indirect address gives error 0006
// (RQ12) bit register range 0091, length 0092
// (RQ13) bit register moves one bit per execution
// (RQ14) start address and signed length define register
// (RQ15) positive length enters low, exits high
// (RQ16) negative length enters high, exits low
// (RQ17) every bit shifted out goes to overflow
// (RQ18) length magnitude at most sixty-four
// (RQ19) highest bit address from start plus length
// (RQ20) program runs bit register once per scan
// (RQ21) lamp op lights for nonzero byte
// (RQ22) forced item or io error also lights
// (RQ23) clean completion drives enable_out high
`timescale 1ns/10ps
module srbu_core
    import srbu_pkg::*;
#(
    parameter int BSR_MAX = srbu_pkg::SRBU_BSR_MAX
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic enable_in,
    input wire srbu_pkg::srbu_req_t req,
    input wire logic cfg_lamp_on_force,
    input wire logic cfg_lamp_on_io_error,
    input wire logic item_forced,
    input wire logic module_io_error,
    output logic enable_out,
    output logic [15:0] error_code,
    output logic [31:0] result,
    output logic zero_flag,
    output logic overflow_flag,
    output logic [63:0] bit_reg,
    output logic [srbu_pkg::SRBU_BIT_ADDR_W-1:0] bit_reg_msb_addr,
    output logic fault_diag_lamp
);
    import srbu_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers for the asynchronous fault inputs
    logic [1:0] forced_sync; // [0] is only read by [1]
    logic [1:0] ioerr_sync; // [0] is only read by [1]

    // status pins come from other logic outside this clock, so two stages
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            forced_sync <= 2'h0;
            ioerr_sync <= 2'h0;
        end else begin
            forced_sync <= {forced_sync[0], item_forced};
            ioerr_sync <= {ioerr_sync[0], module_io_error};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shift and rotate datapath
    logic [5:0] width; // active operand width
    logic [31:0] mask; // bits that belong to the operand
    logic [31:0] opnd; // operand cut to its width, unsigned
    logic [5:0] eff_cnt; // saturated or reduced count
    logic [63:0] dbl; // operand replicated for rotates
    logic [31:0] next_result;
    logic next_ovf_valid; // overflow flag is to be written
    logic next_ovf;
    logic next_zero;
    logic [63:0] wide; // scratch for shifts out of range

    always_comb begin
        case (req.size)
            SRBU_SZ_BYTE: width = 6'(SRBU_BYTE_W);
            SRBU_SZ_WORD: width = 6'(SRBU_WORD_W);
            default: width = 6'(SRBU_DWORD_W);
        endcase
        mask = (width == 6'(SRBU_DWORD_W)) ? 32'hFFFFFFFF : ((32'h1 << width) - 32'h1);
        // no sign extension: the value is masked, never widened by sign [RQ5]
        opnd = req.operand & mask; // [RQ5]
    end

    // compute result, overflow and zero flags for the selected operation
    always_comb begin
        eff_cnt = 6'h00;
        dbl = {32'h00000000, opnd};
        wide = 64'h0;
        next_result = opnd;
        next_ovf_valid = 1'b0;
        next_ovf = 1'b0;
        next_zero = (opnd == 32'h0);
        case (req.op)
            SRBU_OP_SHIFT_LEFT, SRBU_OP_SHIFT_RIGHT: begin
                // saturate the count at the operand width [RQ2]
                eff_cnt = ({2'h0, req.count} >= {4'h0, width}) ? width : req.count[5:0];
                if (req.op == SRBU_OP_SHIFT_LEFT) begin
                    // zeros enter from the right [RQ1]
                    wide = {32'h00000000, opnd} << eff_cnt;
                    next_result = wide[31:0] & mask;
                    if (eff_cnt != 6'h00) begin
                        next_ovf = wide[width]; // last bit beyond the top [RQ3]
                    end
                end else begin
                    // zeros enter from the left [RQ1]
                    wide = {opnd, 32'h00000000} >> eff_cnt;
                    next_result = wide[63:32];
                    if (eff_cnt != 6'h00) begin
                        next_ovf = wide[31]; // last bit below bit zero [RQ3]
                    end
                end
                next_ovf_valid = (eff_cnt != 6'h00); // [RQ3]
                next_zero = (next_result == 32'h0); // [RQ4]
            end
            SRBU_OP_ROTATE_LEFT, SRBU_OP_ROTATE_RIGHT: begin
                // reduce modulo a power of two width [RQ7]
                eff_cnt = {1'b0, req.count[4:0]} & (width - 6'h01);
                // replicate the operand so bits leaving one end reappear [RQ6]
                case (req.size)
                    SRBU_SZ_BYTE: dbl = {32'h0, opnd[7:0], opnd[7:0], opnd[7:0], opnd[7:0]};
                    SRBU_SZ_WORD: dbl = {32'h0, opnd[15:0], opnd[15:0]};
                    default: dbl = {opnd, opnd};
                endcase
                if (req.op == SRBU_OP_ROTATE_LEFT) begin
                    wide = dbl << eff_cnt;
                    wide = wide >> width; // [RQ6]
                    next_result = wide[31:0] & mask;
                    next_ovf = next_result[0]; // last bit carried round [RQ9]
                end else begin
                    wide = dbl >> eff_cnt; // [RQ6]
                    next_result = wide[31:0] & mask;
                    next_ovf = next_result[5'(width - 6'h01)]; // [RQ9]
                end
                // zero count: operand unchanged, overflow kept [RQ8]
                next_ovf_valid = (eff_cnt != 6'h00); // [RQ8] [RQ9]
                next_zero = (opnd == 32'h0); // [RQ10]
            end
            default: begin
                next_result = opnd;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // bit shift register
    logic [6:0] len_mag; // magnitude of the signed length
    logic len_neg; // shift minus
    logic len_bad; // zero or above the maximum
    logic [63:0] len_mask; // bits in use
    logic [63:0] next_bit_reg;
    logic bsr_out; // bit leaving the register

    always_comb begin
        len_neg = req.length[7]; // sign gives the direction [RQ14]
        len_mag = len_neg ? 7'(-req.length) : req.length[6:0]; // [RQ14]
        len_bad = (len_mag == 7'h00) || ({25'h0, len_mag} > 32'(BSR_MAX)); // [RQ18]
        len_mask = (len_mag >= 7'h40) ? 64'hFFFFFFFFFFFFFFFF : ((64'h1 << len_mag) - 64'h1);
        if (len_neg) begin
            // data in at the top, out of the start bit [RQ16]
            bsr_out = bit_reg[0]; // [RQ16]
            next_bit_reg = ((bit_reg & len_mask) >> 1)
                | ({63'h0, req.data_bit} << (len_mag - 7'h01)); // [RQ13] [RQ16]
        end else begin
            // data in at the start bit, out of the top [RQ15]
            bsr_out = bit_reg[6'(len_mag - 7'h01)]; // [RQ15]
            next_bit_reg = ((bit_reg << 1) | {63'h0, req.data_bit}) & len_mask; // [RQ13]
        end
    end

    // locate the highest register bit for software to see
    srbu_msb_addr srbu_msb_addr_i (
        .start_addr(req.start_addr),
        .length_mag(len_mag),
        .msb_addr(bit_reg_msb_addr)
    );

    ////////////////////////////////////////////////////////////////////////////
    // error selection
    logic [15:0] next_err;
    logic active; // an operation runs this cycle

    always_comb begin
        active = enable_in && (req.op != SRBU_OP_NONE);
        next_err = SRBU_ERR_NONE;
        if (req.indirect_bad) begin
            next_err = SRBU_ERR_INDIRECT; // [RQ11]
        end else if (req.op == SRBU_OP_BIT_SHIFT_REG) begin
            if (req.operand_out_of_range) begin
                next_err = SRBU_ERR_RANGE; // [RQ12]
            end else if (len_bad) begin
                next_err = SRBU_ERR_COUNT; // [RQ12] [RQ18]
            end
        end
    end

    // enable_out and error code, one cycle after the request
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            enable_out <= 1'b0;
            error_code <= SRBU_ERR_NONE;
        end else if (active) begin
            enable_out <= (next_err == SRBU_ERR_NONE); // [RQ11] [RQ12] [RQ23]
            error_code <= next_err;
        end else begin
            enable_out <= 1'b0; // no power flow, nothing passed on
            error_code <= SRBU_ERR_NONE;
        end
    end

    // result register of shifts and rotates
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            result <= SRBU_RES_RST;
        end else if (active && next_err == SRBU_ERR_NONE && req.op >= SRBU_OP_SHIFT_LEFT
                && req.op <= SRBU_OP_ROTATE_RIGHT) begin
            result <= next_result;
        end
    end

    // flags: errors leave them untouched so a failed op changes nothing
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            zero_flag <= 1'b0;
            overflow_flag <= 1'b0;
        end else if (active && next_err == SRBU_ERR_NONE) begin
            if (req.op >= SRBU_OP_SHIFT_LEFT && req.op <= SRBU_OP_ROTATE_RIGHT) begin
                zero_flag <= next_zero; // [RQ4] [RQ10]
                if (next_ovf_valid) begin
                    overflow_flag <= next_ovf; // [RQ3] [RQ9]
                end
            end else if (req.op == SRBU_OP_BIT_SHIFT_REG) begin
                overflow_flag <= bsr_out; // [RQ17]
            end
        end
    end

    // register storage; advances once per accepted execution, caller paces it [RQ20]
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bit_reg <= SRBU_BSR_RST;
        end else if (active && next_err == SRBU_ERR_NONE && req.op == SRBU_OP_BIT_SHIFT_REG) begin
            bit_reg <= next_bit_reg; // [RQ13]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // diagnostic lamp
    logic diag_lamp_op; // state set by the lamp operation

    // lamp op stores whether its byte is nonzero
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            diag_lamp_op <= 1'b0;
        end else if (active && !req.indirect_bad && req.op == SRBU_OP_DIAG_LAMP) begin
            diag_lamp_op <= (req.operand[7:0] != 8'h00); // [RQ21]
        end
    end

    // configured fault conditions are ORed in; both off leaves the op alone
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            fault_diag_lamp <= 1'b0;
        end else begin
            fault_diag_lamp <= diag_lamp_op || (cfg_lamp_on_force && forced_sync[1])
                || (cfg_lamp_on_io_error && ioerr_sync[1]); // [RQ22]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    error_path_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (enable_in && req.op != SRBU_OP_NONE && req.indirect_bad)
            |=> (!enable_out && error_code == SRBU_ERR_INDIRECT)) // [RQ11]
        else $error("indirect error not reported");
    bsr_count_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (enable_in && req.op == SRBU_OP_BIT_SHIFT_REG && !req.indirect_bad
            && !req.operand_out_of_range && req.length == 8'sh00)
            |=> (error_code == SRBU_ERR_COUNT)) // [RQ12]
        else $error("count error not reported");
    clean_enable_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (active && next_err == SRBU_ERR_NONE) |=> enable_out) // [RQ23]
        else $error("enable_out low after clean op");
    shift_sat_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (active && !req.indirect_bad && req.op == SRBU_OP_SHIFT_LEFT
            && req.count >= 8'h20) |=> (result == 32'h0 && zero_flag)) // [RQ2]
        else $error("saturated shift not all zero");
    rot_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (active && !req.indirect_bad && req.op == SRBU_OP_ROTATE_RIGHT
            && req.count[4:0] == 5'h00 && req.size == SRBU_SZ_DWORD)
            |=> (result == $past(opnd) && $stable(overflow_flag))) // [RQ8]
        else $error("zero rotate changed state");
    rot_flag_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (active && !req.indirect_bad && req.op == SRBU_OP_ROTATE_LEFT)
            |=> (zero_flag == ($past(opnd) == 32'h0))) // [RQ10]
        else $error("rotate zero flag wrong");
    bsr_plus_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (active && next_err == SRBU_ERR_NONE && req.op == SRBU_OP_BIT_SHIFT_REG
            && !len_neg) |=> (bit_reg[0] == $past(req.data_bit)
            && overflow_flag == $past(bsr_out))) // [RQ15] [RQ17]
        else $error("shift plus entry wrong");
    lamp_op_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (active && !req.indirect_bad && req.op == SRBU_OP_DIAG_LAMP
            && req.operand[7:0] != 8'h00) |=> ##1 fault_diag_lamp) // [RQ21]
        else $error("lamp not lit by operation");
endmodule

// file: pkg/srbu_pkg.sv
// package of constants and carrier types for the shift, rotate and bit register unit
package srbu_pkg;
    // operand widths in bits
    localparam int SRBU_BYTE_W = 8;
    localparam int SRBU_WORD_W = 16;
    localparam int SRBU_DWORD_W = 32;
    // longest bit shift register, either direction
    localparam int SRBU_BSR_MAX = 64;
    // bit address layout: byte index above, bit-in-byte in the low three bits
    localparam int SRBU_BIT_IDX_W = 3;
    localparam int SRBU_BYTE_ADDR_W = 13;
    localparam int SRBU_BIT_ADDR_W = SRBU_BYTE_ADDR_W + SRBU_BIT_IDX_W;
    // error codes reported with enable_out low
    localparam logic [15:0] SRBU_ERR_NONE = 16'h0000;
    localparam logic [15:0] SRBU_ERR_INDIRECT = 16'h0006;
    localparam logic [15:0] SRBU_ERR_RANGE = 16'h0091;
    localparam logic [15:0] SRBU_ERR_COUNT = 16'h0092;
    // reset values
    localparam logic [63:0] SRBU_BSR_RST = 64'h0000000000000000;
    localparam logic [31:0] SRBU_RES_RST = 32'h00000000;

    // operation selector
    typedef enum logic [3:0] {
        SRBU_OP_NONE,
        SRBU_OP_SHIFT_LEFT,
        SRBU_OP_SHIFT_RIGHT,
        SRBU_OP_ROTATE_LEFT,
        SRBU_OP_ROTATE_RIGHT,
        SRBU_OP_BIT_SHIFT_REG,
        SRBU_OP_DIAG_LAMP
    } srbu_op_t;

    // operand size selector
    typedef enum logic [1:0] {
        SRBU_SZ_BYTE,
        SRBU_SZ_WORD,
        SRBU_SZ_DWORD
    } srbu_size_t;

    // one operation request
    typedef struct packed {
        srbu_op_t op;
        srbu_size_t size;
        logic [31:0] operand;
        logic [7:0] count;
        logic indirect_bad;
        logic operand_out_of_range;
        logic data_bit;
        logic [SRBU_BIT_ADDR_W-1:0] start_addr;
        logic signed [7:0] length;
    } srbu_req_t;

    // flags produced by an operation
    typedef struct packed {
        logic zero_flag;
        logic overflow_flag;
    } srbu_flags_t;
endpackage

// file: logic/srbu_msb_addr.sv
// address of the highest bit of the bit shift register
`timescale 1ns/10ps
module srbu_msb_addr
    import srbu_pkg::*;
(
    input wire logic [srbu_pkg::SRBU_BIT_ADDR_W-1:0] start_addr,
    input wire logic [6:0] length_mag,
    output logic [srbu_pkg::SRBU_BIT_ADDR_W-1:0] msb_addr
);
    logic [SRBU_BIT_ADDR_W-1:0] offset; // length - 1 + start bit

    // byte part and remainder fall out of the packed bit address [RQ19]
    always_comb begin
        offset = SRBU_BIT_ADDR_W'(length_mag) - SRBU_BIT_ADDR_W'(1)
            + SRBU_BIT_ADDR_W'(start_addr[SRBU_BIT_IDX_W-1:0]);
        msb_addr = {start_addr[SRBU_BIT_ADDR_W-1:SRBU_BIT_IDX_W], {SRBU_BIT_IDX_W{1'b0}}}
            + offset; // [RQ19]
    end
endmodule

// file: verification/srbu_bench.sv
// self-checking bench for the shift, rotate and bit register unit
`timescale 1ns/10ps
module shift_rotate_bitreg_unit_bench;
    import srbu_pkg::*;
    // stimulus, all driven on the falling edge
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic enable_in = 1'b0;
    srbu_req_t req = '0;
    logic cfg_lamp_on_force = 1'b0;
    logic cfg_lamp_on_io_error = 1'b0;
    logic item_forced = 1'b0;
    logic module_io_error = 1'b0;
    // observed outputs
    logic enable_out;
    logic [15:0] error_code;
    logic [31:0] result;
    logic zero_flag;
    logic overflow_flag;
    logic [63:0] bit_reg;
    logic [SRBU_BIT_ADDR_W-1:0] bit_reg_msb_addr;
    logic fault_diag_lamp;
    int failures = 0;
    int n_checks = 0;
    // expected state, built only from the rules
    logic [31:0] e_res = '0;
    logic e_z = 1'b0;
    logic e_v = 1'b0;
    logic [63:0] e_bsr = '0;
    logic [63:0] e_mk = '1; // bits of the register that the current length covers
    logic e_en = 1'b0; // enable_out may only rise once out of reset

    srbu_core srbu_core_i (.mclk(mclk), .rst_b(rst_b), .enable_in(enable_in), .req(req),
        .cfg_lamp_on_force(cfg_lamp_on_force), .cfg_lamp_on_io_error(cfg_lamp_on_io_error),
        .item_forced(item_forced), .module_io_error(module_io_error),
        .enable_out(enable_out), .error_code(error_code), .result(result),
        .zero_flag(zero_flag), .overflow_flag(overflow_flag), .bit_reg(bit_reg),
        .bit_reg_msb_addr(bit_reg_msb_addr), .fault_diag_lamp(fault_diag_lamp));

    always #5 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////////
    // verdict, the single end of the run
    task automatic close_out();
        if (failures == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // one-bit outputs
    task automatic chk_bit(input string what, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %b seen %b", what, e, g);
        end
    endtask

    // vector outputs, zero extended to 64 bits
    task automatic chk_vec(input string what, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    // n rising edges, then settle on the next falling edge
    task automatic cycle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask

    // enable stays high so ops run back to back; idle() drops it
    task automatic issue(input srbu_op_t op, input srbu_size_t sz, input logic [31:0] opd,
            input logic [7:0] cnt);
        req.op = op;
        req.size = sz;
        req.operand = opd;
        req.count = cnt;
        enable_in = 1'b1;
        cycle(1);
    endtask

    task automatic idle();
        enable_in = 1'b0;
        cycle(1);
    endtask

    // completion with a given code; a refusal must leave results alone
    task automatic chk_done(input logic [15:0] code);
        chk_bit("enable_out", e_en && (code == SRBU_ERR_NONE), enable_out);
        chk_vec("error_code", {48'h0, code}, {48'h0, error_code});
        chk_vec("result", {32'h0, e_res}, {32'h0, result});
        chk_bit("overflow_flag", e_v, overflow_flag);
        chk_vec("bit_reg", e_bsr & e_mk, bit_reg & e_mk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // shift and rotate model; overflow kept when nothing leaves the operand
    function automatic void model_sr(input srbu_op_t op, input srbu_size_t sz,
            input logic [31:0] opd, input logic [7:0] cnt);
        int w;
        int n;
        logic [63:0] m;
        logic [63:0] v;
        logic [63:0] t;
        w = (sz == SRBU_SZ_BYTE) ? SRBU_BYTE_W : (sz == SRBU_SZ_WORD) ? SRBU_WORD_W : SRBU_DWORD_W;
        m = (64'h1 << w) - 64'h1;
        v = {32'h0, opd} & m;
        if (op == SRBU_OP_SHIFT_LEFT || op == SRBU_OP_SHIFT_RIGHT) begin
            n = (int'(cnt) >= w) ? w : int'(cnt);
            t = (op == SRBU_OP_SHIFT_LEFT) ? (v << n) : (v >> n);
            if (n > 0) begin
                e_v = (op == SRBU_OP_SHIFT_LEFT) ? t[w] : v[n-1];
            end
        end else begin
            n = int'(cnt) % w;
            t = (op == SRBU_OP_ROTATE_LEFT) ? ((v << n) | (v >> (w - n)))
                                            : ((v >> n) | (v << (w - n)));
            t = t & m;
            if (n > 0) begin
                e_v = (op == SRBU_OP_ROTATE_LEFT) ? t[0] : t[w-1];
            end
        end
        t = t & m;
        e_res = t[31:0];
        e_z = (v == 64'h0) || (t == 64'h0);
    endfunction

    // one bit register step, length sign chooses the direction
    task automatic bsr_step(input logic signed [7:0] len, input logic d);
        int m;
        logic [63:0] v;
        m = (len < 0) ? -int'(len) : int'(len);
        e_mk = (m >= 64) ? '1 : ((64'h1 << m) - 64'h1);
        v = e_bsr & e_mk;
        e_v = (len > 0) ? v[m-1] : v[0];
        v = (len > 0) ? ((v << 1) | {63'h0, d}) : ((v >> 1) | ({63'h0, d} << (m - 1)));
        e_bsr = (e_bsr & ~e_mk) | (v & e_mk);
        req.length = len;
        req.data_bit = d;
        issue(SRBU_OP_BIT_SHIFT_REG, SRBU_SZ_BYTE, 32'h0, 8'h00);
        chk_done(SRBU_ERR_NONE);
    endtask

    // highest bit address, worked out as byte plus quotient, bit from remainder
    task automatic msb_chk(input logic [15:0] sa, input logic signed [7:0] len);
        int m;
        int s;
        m = (len < 0) ? -int'(len) : int'(len);
        s = m - 1 + int'(sa[2:0]);
        req.start_addr = sa;
        req.length = len;
        #1;
        chk_vec("msb_addr", 64'((int'(sa[15:3]) + s / 8) * 8 + s % 8), 64'(bit_reg_msb_addr));
        cycle(0);
    endtask

    // lamp op with a byte operand, then let the lamp pipeline settle
    task automatic lamp_op(input logic [31:0] val, input logic e);
        issue(SRBU_OP_DIAG_LAMP, SRBU_SZ_BYTE, val, 8'h00);
        idle();
        cycle(3);
        chk_bit("lamp", e, fault_diag_lamp);
    endtask

    // lamp after a configuration or fault pin change
    task automatic lamp_wait(input logic e);
        cycle(4);
        chk_bit("lamp", e, fault_diag_lamp);
    endtask

    // a hang ends the run through the same verdict
    initial begin
        repeat (50000) @(posedge mclk);
        failures++;
        $display("[FAIL] watchdog expected finish seen hang");
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        srbu_op_t ops[4] = '{SRBU_OP_SHIFT_LEFT, SRBU_OP_SHIFT_RIGHT,
                             SRBU_OP_ROTATE_LEFT, SRBU_OP_ROTATE_RIGHT};
        srbu_size_t szs[3] = '{SRBU_SZ_BYTE, SRBU_SZ_WORD, SRBU_SZ_DWORD};
        logic [7:0] cnts[12] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h08, 8'h0F,
                                 8'h10, 8'h11, 8'h1F, 8'h20, 8'h21, 8'hFF};
        logic signed [7:0] lens[5] = '{8'sd4, -8'sd4, 8'sd64, -8'sd64, 8'sd1};
        cycle(10);
        chk_done(SRBU_ERR_NONE);
        rst_b = 1'b1;
        e_en = 1'b1;
        // every shift and rotate, all sizes, counts around each width
        foreach (ops[i]) foreach (szs[j]) foreach (cnts[k]) for (int p = 0; p < 2; p++) begin
            issue(ops[i], szs[j], (p == 0) ? 32'hB3C581E7 : 32'h0, cnts[k]);
            model_sr(ops[i], szs[j], (p == 0) ? 32'hB3C581E7 : 32'h0, cnts[k]);
            chk_done(SRBU_ERR_NONE);
            chk_bit("zero_flag", e_z, zero_flag);
        end
        idle();
        chk_bit("enable_out idle", 1'b0, enable_out);
        // bit register in both directions, longest length included
        foreach (lens[i]) for (int n = 0; n < 70; n++) begin
            bsr_step(lens[i], n[0] ^ n[2] ^ (n > 40));
        end
        // bad indirect address refuses every operation, lamp included
        req.indirect_bad = 1'b1;
        foreach (ops[i]) begin
            issue(ops[i], SRBU_SZ_WORD, 32'h00FF, 8'h03);
            chk_done(SRBU_ERR_INDIRECT);
        end
        req.operand_out_of_range = 1'b1;
        issue(SRBU_OP_BIT_SHIFT_REG, SRBU_SZ_BYTE, 32'h0, 8'h00);
        chk_done(SRBU_ERR_INDIRECT);
        issue(SRBU_OP_DIAG_LAMP, SRBU_SZ_BYTE, 32'h00FF, 8'h00);
        chk_done(SRBU_ERR_INDIRECT);
        lamp_op(32'h00FF, 1'b0);
        req.indirect_bad = 1'b0;
        // range beats a bad length; lengths 0 and beyond 64 refused
        req.length = 8'sd0;
        issue(SRBU_OP_BIT_SHIFT_REG, SRBU_SZ_BYTE, 32'h0, 8'h00);
        chk_done(SRBU_ERR_RANGE);
        req.operand_out_of_range = 1'b0;
        foreach (lens[i]) begin
            req.length = (i == 0) ? 8'sd0 : (i == 1) ? 8'sd65 : (i == 2) ? -8'sd65
                : (i == 3) ? 8'sh80 : 8'sd127;
            issue(SRBU_OP_BIT_SHIFT_REG, SRBU_SZ_BYTE, 32'h0, 8'h00);
            chk_done(SRBU_ERR_COUNT);
        end
        idle();
        msb_chk(16'h010C, 8'sd14);
        msb_chk(16'h010C, -8'sd14);
        msb_chk(16'h0037, 8'sd64);
        msb_chk(16'h0000, 8'sd1);
        // lamp op alone, upper operand bits ignored
        lamp_op(32'h0000_0005, 1'b1);
        lamp_op(32'hFFFF_FF00, 1'b0);
        lamp_op(32'h0000_0080, 1'b1);
        lamp_op(32'h0, 1'b0);
        // fault options light the lamp only when enabled
        item_forced = 1'b1;
        lamp_wait(1'b0);
        cfg_lamp_on_force = 1'b1;
        lamp_wait(1'b1);
        item_forced = 1'b0;
        module_io_error = 1'b1;
        lamp_wait(1'b0);
        cfg_lamp_on_io_error = 1'b1;
        lamp_wait(1'b1);
        lamp_op(32'h0, 1'b1);
        module_io_error = 1'b0;
        lamp_wait(1'b0);
        // reset in mid-run clears the registered outputs
        rst_b = 1'b0;
        cycle(2);
        e_res = '0;
        e_v = 1'b0;
        e_bsr = '0;
        e_mk = '1;
        e_en = 1'b0;
        chk_done(SRBU_ERR_NONE);
        chk_bit("zero_flag reset", 1'b0, zero_flag);
        rst_b = 1'b1;
        e_en = 1'b1;
        // first request at the edge right after release
        issue(SRBU_OP_SHIFT_LEFT, SRBU_SZ_BYTE, 32'h00000081, 8'h01);
        model_sr(SRBU_OP_SHIFT_LEFT, SRBU_SZ_BYTE, 32'h00000081, 8'h01);
        chk_done(SRBU_ERR_NONE);
        chk_bit("zero_flag", e_z, zero_flag);
        close_out();
    end
endmodule
